//--- logic/cbcr_pkg.sv
// Summary of operation
// [R01] byte 7 bits 4:0 hold block-read byte count, power-up value 8
// [R02] byte indices 8, 9 and 17 are reserved, no configuration function
// [R03] byte 10 bit 6: 0 clears config in power-down, 1 keeps it; resets 1
// [R04] host leaves byte 10 bit 7 at its default 0 when writing
// [R05] byte 11 bits 1:0 stop level: 00 low/low, 01 hiz, 10 high/low, 11 low/high
// [R06] impedance codes: out0 byte 12 bits 7:6, out1 byte 13 bits 3:2
// [R07] termination codes at bytes 14, 15, 16; 00 none, 01 down, 10 up, 11 both
// [R08] termination powers up pull-down for enables, pull-up for power-good input
// [R09] byte 18 bits 3 and 5 set enable input active level; reset 0
// [R10] byte 19 bit 0 sets power-down level of power-good input; reset 0
// [R11] software-cleared output enable forces output to the stop level
// [R12] reserved bits and indices ignore writes and read back stable zero, except byte 10 bit 7, which stores writes and reads back
`default_nettype none
package cbcr_pkg;
  localparam logic [7:0] IDX_BYTE_COUNT = 8'h07;
  localparam logic [7:0] IDX_RETENTION = 8'h0a;
  localparam logic [7:0] IDX_STOP_LEVEL = 8'h0b;
  localparam logic [7:0] IDX_OUT0_IMP = 8'h0c;
  localparam logic [7:0] IDX_OUT1_IMP = 8'h0d;
  localparam logic [7:0] IDX_EN0_TERM = 8'h0e;
  localparam logic [7:0] IDX_EN1_TERM = 8'h0f;
  localparam logic [7:0] IDX_PG_TERM = 8'h10;
  localparam logic [7:0] IDX_EN_POL = 8'h12;
  localparam logic [7:0] IDX_PG_POL = 8'h13;

  localparam int BC_LSB = 0;
  localparam int RET_KEEP_BIT = 6;
  localparam int RET_RSVD_BIT = 7;
  localparam int STOP_LSB = 0;
  localparam int IMP0_LSB = 6;
  localparam int IMP1_LSB = 2;
  localparam int EN0_TERM_LSB = 6;
  localparam int EN1_TERM_LSB = 2;
  localparam int PG_TERM_LSB = 0;
  localparam int EN0_POL_BIT = 3;
  localparam int EN1_POL_BIT = 5;
  localparam int PG_POL_BIT = 0;

  localparam logic [4:0] BC_RESET = 5'h08;
  localparam logic RET_KEEP_RESET = 1'b1;
  localparam logic RET_RSVD_RESET = 1'b0;
  localparam logic [1:0] STOP_RESET = 2'h0;
  localparam logic [1:0] IMP_33R = 2'h0;
  localparam logic [1:0] IMP_85R = 2'h1;
  localparam logic [1:0] IMP_100R = 2'h2;
  localparam logic [1:0] TERM_PULL_DOWN = 2'h1;
  localparam logic [1:0] TERM_PULL_UP = 2'h2;
  localparam logic POL_RESET = 1'b0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    CBCR_STOP_LOW_LOW = 2'b00,
    CBCR_STOP_HIZ = 2'b01,
    CBCR_STOP_HIGH_LOW = 2'b10,
    CBCR_STOP_LOW_HIGH = 2'b11
  } cbcr_stop_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cbcr_req_t;

  typedef struct packed {
    logic run;
    logic level_true;
    logic level_comp;
    logic hiz;
  } cbcr_drive_t;

  typedef struct packed {
    logic [1:0] enable0_termination;
    logic [1:0] enable1_termination;
    logic [1:0] powergood_termination;
  } cbcr_term_t;
endpackage
`default_nettype wire

//--- logic/cbcr_regs.sv
`default_nettype none
module cbcr_regs #(
  parameter logic [1:0] IMP0_RESET = cbcr_pkg::IMP_100R,
  parameter logic [1:0] IMP1_RESET = cbcr_pkg::IMP_100R
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire cbcr_pkg::cbcr_req_t req,
  input wire logic [1:0] sw_output_enable,
  input wire logic [1:0] enable_pin,
  input wire logic powergood_powerdown_input,
  output logic [7:0] rd_data_reg,
  output logic rd_valid_reg,
  output logic [4:0] read_count_reg,
  output cbcr_pkg::cbcr_drive_t out0_drive_reg,
  output cbcr_pkg::cbcr_drive_t out1_drive_reg,
  output logic [1:0] out0_impedance_reg,
  output logic [1:0] out1_impedance_reg,
  output cbcr_pkg::cbcr_term_t termination_reg,
  output logic powerdown_reg
);
  logic keep_reg;
  logic rsvd_reg;
  logic [1:0] stop_reg;
  logic enable0_active_level_reg;
  logic enable1_active_level_reg;
  logic pg_level_reg;
  logic pd_now;
  logic clear_cfg;
  logic wr_hit;

  // polarity 0 means active when the pin is low
  function automatic logic level_match(input logic pin, input logic pol);
    level_match = (pin == pol);
  endfunction

  function automatic cbcr_pkg::cbcr_drive_t drive_of(input logic run, input logic [1:0] stop);
    cbcr_pkg::cbcr_drive_t d;
    d = '0;
    d.run = run;
    if (!run) begin
      case (cbcr_pkg::cbcr_stop_t'(stop)) // R05
        cbcr_pkg::CBCR_STOP_HIZ: d.hiz = 1'b1;
        cbcr_pkg::CBCR_STOP_HIGH_LOW: d.level_true = 1'b1;
        cbcr_pkg::CBCR_STOP_LOW_HIGH: d.level_comp = 1'b1;
        default: d = d;
      endcase
    end
    drive_of = d;
  endfunction

  // one write decode shared by the retention, stop, impedance and polarity fields
  function automatic logic wr_at(input logic hit, input logic [7:0] index,
    input logic [7:0] target);
    wr_at = hit && (index == target);
  endfunction

  assign pd_now = level_match(powergood_powerdown_input, pg_level_reg); // R10
  // config clears only while in power-down and retention is off
  assign clear_cfg = pd_now && !keep_reg; // R03
  assign wr_hit = req.wr && !clear_cfg;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_count_reg <= cbcr_pkg::BC_RESET;
    end else if (clear_cfg) begin
      read_count_reg <= cbcr_pkg::BC_RESET;
    end else if (wr_hit && req.index == cbcr_pkg::IDX_BYTE_COUNT) begin
      read_count_reg <= req.wdata[cbcr_pkg::BC_LSB +: 5]; // R01
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      keep_reg <= cbcr_pkg::RET_KEEP_RESET;
      rsvd_reg <= cbcr_pkg::RET_RSVD_RESET;
    end else if (clear_cfg) begin
      keep_reg <= cbcr_pkg::RET_KEEP_RESET;
      rsvd_reg <= cbcr_pkg::RET_RSVD_RESET;
    end else if (wr_at(wr_hit, req.index, cbcr_pkg::IDX_RETENTION)) begin
      keep_reg <= req.wdata[cbcr_pkg::RET_KEEP_BIT]; // R03
      // stored only so it reads back; steers nothing
      rsvd_reg <= req.wdata[cbcr_pkg::RET_RSVD_BIT]; // R04
    end
  end

  // stop level only shows while an output is held off
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stop_reg <= cbcr_pkg::STOP_RESET;
    end else if (clear_cfg) begin
      stop_reg <= cbcr_pkg::STOP_RESET;
    end else if (wr_at(wr_hit, req.index, cbcr_pkg::IDX_STOP_LEVEL)) begin
      stop_reg <= req.wdata[cbcr_pkg::STOP_LSB +: 2]; // R05
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out0_impedance_reg <= IMP0_RESET;
    end else if (clear_cfg) begin
      out0_impedance_reg <= IMP0_RESET;
    end else if (wr_at(wr_hit, req.index, cbcr_pkg::IDX_OUT0_IMP)) begin
      out0_impedance_reg <= req.wdata[cbcr_pkg::IMP0_LSB +: 2]; // R06
    end
  end

  // reserved code 11 is stored as written; the driver decides what it means
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out1_impedance_reg <= IMP1_RESET;
    end else if (clear_cfg) begin
      out1_impedance_reg <= IMP1_RESET;
    end else if (wr_at(wr_hit, req.index, cbcr_pkg::IDX_OUT1_IMP)) begin
      out1_impedance_reg <= req.wdata[cbcr_pkg::IMP1_LSB +: 2]; // R06
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      termination_reg.enable0_termination <= cbcr_pkg::TERM_PULL_DOWN; // R08
      termination_reg.enable1_termination <= cbcr_pkg::TERM_PULL_DOWN; // R08
      termination_reg.powergood_termination <= cbcr_pkg::TERM_PULL_UP; // R08
    end else if (clear_cfg) begin
      termination_reg.enable0_termination <= cbcr_pkg::TERM_PULL_DOWN;
      termination_reg.enable1_termination <= cbcr_pkg::TERM_PULL_DOWN;
      termination_reg.powergood_termination <= cbcr_pkg::TERM_PULL_UP;
    end else if (wr_hit) begin
      if (req.index == cbcr_pkg::IDX_EN0_TERM) begin
        termination_reg.enable0_termination <= req.wdata[cbcr_pkg::EN0_TERM_LSB +: 2]; // R07
      end
      if (req.index == cbcr_pkg::IDX_EN1_TERM) begin
        termination_reg.enable1_termination <= req.wdata[cbcr_pkg::EN1_TERM_LSB +: 2]; // R07
      end
      if (req.index == cbcr_pkg::IDX_PG_TERM) begin
        termination_reg.powergood_termination <= req.wdata[cbcr_pkg::PG_TERM_LSB +: 2]; // R07
      end
    end
  end

  // polarity survives a clear so the device can leave power-down cleanly
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable0_active_level_reg <= cbcr_pkg::POL_RESET;
      enable1_active_level_reg <= cbcr_pkg::POL_RESET;
    end else if (wr_at(wr_hit, req.index, cbcr_pkg::IDX_EN_POL)) begin
      enable0_active_level_reg <= req.wdata[cbcr_pkg::EN0_POL_BIT]; // R09
      enable1_active_level_reg <= req.wdata[cbcr_pkg::EN1_POL_BIT]; // R09
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pg_level_reg <= cbcr_pkg::POL_RESET;
    end else if (wr_at(wr_hit, req.index, cbcr_pkg::IDX_PG_POL)) begin
      pg_level_reg <= req.wdata[cbcr_pkg::PG_POL_BIT]; // R10
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg <= cbcr_pkg::READ_ZERO;
    end else begin
      rd_valid_reg <= req.rd;
      if (req.rd) begin
        rd_data_reg <= cbcr_pkg::READ_ZERO; // R12
        case (req.index) // R02
          cbcr_pkg::IDX_BYTE_COUNT: rd_data_reg[cbcr_pkg::BC_LSB +: 5] <= read_count_reg;
          cbcr_pkg::IDX_RETENTION: begin
            rd_data_reg[cbcr_pkg::RET_KEEP_BIT] <= keep_reg;
            rd_data_reg[cbcr_pkg::RET_RSVD_BIT] <= rsvd_reg;
          end
          cbcr_pkg::IDX_STOP_LEVEL: rd_data_reg[cbcr_pkg::STOP_LSB +: 2] <= stop_reg;
          cbcr_pkg::IDX_OUT0_IMP: rd_data_reg[cbcr_pkg::IMP0_LSB +: 2] <= out0_impedance_reg;
          cbcr_pkg::IDX_OUT1_IMP: rd_data_reg[cbcr_pkg::IMP1_LSB +: 2] <= out1_impedance_reg;
          cbcr_pkg::IDX_EN0_TERM:
            rd_data_reg[cbcr_pkg::EN0_TERM_LSB +: 2] <= termination_reg.enable0_termination;
          cbcr_pkg::IDX_EN1_TERM:
            rd_data_reg[cbcr_pkg::EN1_TERM_LSB +: 2] <= termination_reg.enable1_termination;
          cbcr_pkg::IDX_PG_TERM:
            rd_data_reg[cbcr_pkg::PG_TERM_LSB +: 2] <= termination_reg.powergood_termination;
          cbcr_pkg::IDX_EN_POL: begin
            rd_data_reg[cbcr_pkg::EN0_POL_BIT] <= enable0_active_level_reg;
            rd_data_reg[cbcr_pkg::EN1_POL_BIT] <= enable1_active_level_reg;
          end
          cbcr_pkg::IDX_PG_POL: rd_data_reg[cbcr_pkg::PG_POL_BIT] <= pg_level_reg;
          default: rd_data_reg <= cbcr_pkg::READ_ZERO; // R12
        endcase
      end
    end
  end

  // software disable overrides the pin; power-down stops both outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out0_drive_reg <= '0;
    end else begin
      out0_drive_reg <= drive_of(sw_output_enable[0] && !pd_now &&
        level_match(enable_pin[0], enable0_active_level_reg), stop_reg); // R11
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out1_drive_reg <= '0;
    end else begin
      out1_drive_reg <= drive_of(sw_output_enable[1] && !pd_now &&
        level_match(enable_pin[1], enable1_active_level_reg), stop_reg); // R11
    end
  end

  // same pin sample as the drives, so flag and outputs never disagree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      powerdown_reg <= 1'b0;
    end else begin
      powerdown_reg <= pd_now; // R10
    end
  end
endmodule
`default_nettype wire

//--- sim/cbcr_host.sv
`default_nettype none
module cbcr_host (
  input wire logic clk_sys,
  input wire logic rd_valid_reg,
  input wire logic [7:0] rd_data_reg,
  output var cbcr_pkg::cbcr_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one byte per request, strobe held for exactly one edge
  task automatic put(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, idx, (idx == cbcr_pkg::IDX_RETENTION) ? {1'b0, d[6:0]} : d};
    @(posedge clk_sys);
    req <= '0;
  endtask
  task automatic get(input logic [7:0] idx, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    req <= '{1'b0, 1'b1, idx, 8'h00};
    @(posedge clk_sys);
    req <= '0;
    #1;
    v = rd_valid_reg;
    d = rd_data_reg;
  endtask
endmodule
`default_nettype wire

//--- sim/cbcr_regs_chk.sv
`default_nettype none
module cbcr_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire cbcr_pkg::cbcr_req_t req,
  input wire logic [1:0] sw_output_enable,
  input wire logic [7:0] rd_data_reg,
  input wire logic rd_valid_reg,
  input wire logic [4:0] read_count_reg,
  input wire cbcr_pkg::cbcr_drive_t out0_drive_reg,
  input wire logic [1:0] out0_impedance_reg,
  input wire cbcr_pkg::cbcr_term_t termination_reg,
  input wire logic powerdown_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // writes only checked outside power-down, where a clear may win
  property p_rd_ans; req.rd |=> rd_valid_reg; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_quiet; !req.rd |=> !rd_valid_reg; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("spurious read valid");
  property p_rsvd; req.rd && req.index inside {8'h08, 8'h09, 8'h11} |=> rd_data_reg == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved index not zero");
  property p_bc_rd;
    req.rd && req.index == 8'h07 |=> rd_data_reg == {3'h0, $past(read_count_reg)};
  endproperty
  a_bc_rd: assert property (p_bc_rd) else $error("byte count read wrong");
  property p_bc_wr;
    req.wr && req.index == 8'h07 && !powerdown_reg ##1 !powerdown_reg
      |-> read_count_reg == $past(req.wdata[4:0]);
  endproperty
  a_bc_wr: assert property (p_bc_wr) else $error("byte count write lost");
  property p_imp_wr;
    req.wr && req.index == 8'h0c && !powerdown_reg ##1 !powerdown_reg
      |-> out0_impedance_reg == $past(req.wdata[7:6]);
  endproperty
  a_imp_wr: assert property (p_imp_wr) else $error("impedance write lost");
  property p_term_wr; req.wr && req.index == 8'h10 && !powerdown_reg ##1 !powerdown_reg
    |-> termination_reg.powergood_termination == $past(req.wdata[1:0]); endproperty
  a_term_wr: assert property (p_term_wr) else $error("termination write lost");
  property p_sw_off; !sw_output_enable[0] ##1 !sw_output_enable[0] |-> !out0_drive_reg.run;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("disabled output runs");
  property p_hiz;
    out0_drive_reg.hiz |-> !out0_drive_reg.run && !out0_drive_reg.level_true
      && !out0_drive_reg.level_comp;
  endproperty
  a_hiz: assert property (p_hiz) else $error("hiz with level driven");
endmodule
bind cbcr_regs cbcr_chk u_chk (.clk_sys, .reset_n, .req, .sw_output_enable, .rd_data_reg,
  .rd_valid_reg, .read_count_reg, .out0_drive_reg, .out0_impedance_reg, .termination_reg,
  .powerdown_reg);
`default_nettype wire

//--- sim/tb_clock_buffer_config_regs.sv
`default_nettype none
module tb_clock_buffer_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] sw_output_enable = 2'h3;
  logic [1:0] enable_pin = 2'h0;
  logic powergood_powerdown_input = 1'b1;
  cbcr_pkg::cbcr_req_t req;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic [4:0] read_count_reg;
  cbcr_pkg::cbcr_drive_t out0_drive_reg;
  cbcr_pkg::cbcr_drive_t out1_drive_reg;
  logic [1:0] out0_impedance_reg;
  logic [1:0] out1_impedance_reg;
  cbcr_pkg::cbcr_term_t termination_reg;
  logic powerdown_reg;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] idx_t [13] = '{8'h07, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h12,
    8'h13, 8'h08, 8'h09, 8'h11};
  logic [7:0] rst_t [13] = '{8'h08, 8'h40, 8'h00, 8'h80, 8'h08, 8'h40, 8'h04, 8'h02, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] ff_t [13] = '{8'h1f, 8'h40, 8'h03, 8'hc0, 8'h0c, 8'hc0, 8'h0c, 8'h03, 8'h28,
    8'h01, 8'h00, 8'h00, 8'h00};
  cbcr_regs DUT (.clk_sys, .reset_n, .req, .sw_output_enable, .enable_pin,
    .powergood_powerdown_input, .rd_data_reg, .rd_valid_reg, .read_count_reg, .out0_drive_reg,
    .out1_drive_reg, .out0_impedance_reg, .out1_impedance_reg, .termination_reg, .powerdown_reg);
  cbcr_host u_host (.clk_sys, .rd_valid_reg, .rd_data_reg, .req);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_host.get(idx, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask
  task automatic do_reset();
    @(posedge clk_sys) reset_n <= 1'b0;
    sw_output_enable <= 2'h3;
    enable_pin <= 2'h0;
    powergood_powerdown_input <= 1'b1;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic t_defaults();
    do_reset();
    chk({3'h0, read_count_reg}, 8'h08);
    chk({2'h0, termination_reg}, 8'h16);
    for (int i = 0; i < 13; i++) rd_chk(idx_t[i], rst_t[i]);
    $display("defaults test done");
  endtask
  task automatic t_write_all();
    do_reset();
    for (int i = 0; i < 13; i++) u_host.put(idx_t[i], 8'hff);
    for (int i = 0; i < 13; i++) rd_chk(idx_t[i], ff_t[i]);
    chk({6'h00, out0_impedance_reg}, 8'h03);
    chk({6'h00, out1_impedance_reg}, 8'h03);
    chk({2'h0, termination_reg}, 8'h3f);
    chk({7'h00, powerdown_reg}, 8'h01);
    $display("write test done");
  endtask
  task automatic t_stop();
    logic [3:0] exp [4] = '{4'h0, 4'h1, 4'h4, 4'h2};
    do_reset();
    @(posedge clk_sys) sw_output_enable <= 2'h2;
    for (int c = 0; c < 4; c++) begin
      u_host.put(8'h0b, 8'(c));
      repeat (2) @(posedge clk_sys);
      #1 chk({4'h0, out0_drive_reg}, {4'h0, exp[c]});
      chk({4'h0, out1_drive_reg}, 8'h08);
    end
    u_host.put(8'h12, 8'h20);
    repeat (2) @(posedge clk_sys);
    #1 chk({4'h0, out1_drive_reg}, 8'h02);
    $display("stop test done");
  endtask
  task automatic t_pol_pd();
    do_reset();
    @(posedge clk_sys) enable_pin <= 2'h1;
    repeat (2) @(posedge clk_sys);
    #1 chk({4'h0, out0_drive_reg}, 8'h00);
    u_host.put(8'h12, 8'h08);
    repeat (2) @(posedge clk_sys);
    #1 chk({4'h0, out0_drive_reg}, 8'h08);
    u_host.put(8'h07, 8'h05);
    @(posedge clk_sys) powergood_powerdown_input <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, powerdown_reg}, 8'h01);
    chk({4'h0, out0_drive_reg}, 8'h00);
    rd_chk(8'h07, 8'h05);
    u_host.put(8'h0a, 8'h00);
    rd_chk(8'h07, 8'h08);
    rd_chk(8'h12, 8'h08);
    @(posedge clk_sys) powergood_powerdown_input <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk({7'h00, powerdown_reg}, 8'h00);
    $display("polarity test done");
  endtask
  task automatic tally_and_finish();
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #40000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    t_defaults();
    t_write_all();
    t_stop();
    t_pol_pd();
    tally_and_finish();
  end
endmodule
`default_nettype wire
